// ===== hdl/flash_program_erase_control.sv
// Flash program/erase control register block
// Contract
// - Control bits 7..4 select program (0101), sector erase (1010) or hard lock (0110).
// - Writing 1 to control bit 0 starts the operation, 0 stops it, and hardware clears it on completion.
// - The high sector pointer supplies address bits 15..8.
// - Only bit 7 of the low sector pointer supplies address bit 7; bits 6..0 are ignored.
// - Operations are allowed only while the key register holds 1010_0101.
// - Any other key value blocks every program or erase operation.
`timescale 1ns/100ps
module flash_program_erase_control
    import flash_ctl_pkg::*;
(
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RESET_N,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    // Flash array side
    output logic [15:0] FLASH_ADDR,
    output logic PROG_REQ,
    output logic ERASE_REQ,
    output logic LOCK_REQ,
    input wire logic OP_DONE,
    input wire logic OP_FAIL
);
    // ==========================================================
    // State
    typedef struct packed {
        logic [7:0] sec_high;
        logic [7:0] sec_low;
        logic [7:0] key;
        logic [3:0] mode;
        logic fail;
        logic start;
        op_state_e st;
        logic [7:0] rdata;
        logic [15:0] addr;
        logic prog;
        logic erase;
        logic lock;
    } state_s;

    state_s s_r;
    state_s s_nxt;
    logic key_ok;
    logic mode_ok;

    // Key and mode qualifiers
    // Key is compared as a whole byte; any other value keeps the array shut
    assign key_ok = (s_r.key == USER_KEY_VALUE);
    assign mode_ok = (s_r.mode == MODE_PROGRAM) || (s_r.mode == MODE_ERASE)
        || (s_r.mode == MODE_HARD_LOCK);

    // Next-state logic
    always_comb begin
        s_nxt = s_r;
        // Register writes
        // Control bits 3..1 are not writable; fail only moves on erase completion
        if (REG_WR) begin
            unique case (REG_ADDR)
                OFS_SECTOR_HIGH: s_nxt.sec_high = REG_WDATA;
                OFS_SECTOR_LOW: s_nxt.sec_low = REG_WDATA;
                OFS_USER_KEY: s_nxt.key = REG_WDATA;
                OFS_OP_CONTROL: begin
                    s_nxt.mode = REG_WDATA[MODE_MSB:MODE_LSB];
                    s_nxt.start = REG_WDATA[START_BIT];
                end
                default: ;
            endcase
        end
        // Operation sequencing
        unique case (s_r.st)
            ST_IDLE: begin
                // Start with a bad key or an undefined code just falls back
                if (s_r.start) begin
                    if (key_ok && mode_ok) begin
                        s_nxt.st = ST_BUSY;
                        s_nxt.prog = (s_r.mode == MODE_PROGRAM);
                        s_nxt.erase = (s_r.mode == MODE_ERASE);
                        s_nxt.lock = (s_r.mode == MODE_HARD_LOCK);
                    end else if (!(REG_WR && REG_ADDR == OFS_OP_CONTROL)) begin
                        s_nxt.start = 1'b0;
                    end
                end
            end
            ST_BUSY: begin
                // Software stop or completion ends the request
                // A control write in the completion cycle loses to the hardware clear
                if (!s_r.start || OP_DONE) begin
                    s_nxt.st = ST_DONE;
                    s_nxt.prog = 1'b0;
                    s_nxt.erase = 1'b0;
                    s_nxt.lock = 1'b0;
                    if (OP_DONE && s_r.erase) begin
                        s_nxt.fail = OP_FAIL;
                    end
                    s_nxt.start = 1'b0;
                end
            end
            ST_DONE: begin
                s_nxt.st = ST_IDLE;
            end
        endcase
        // Sector address, low bits masked off
        s_nxt.addr = {s_nxt.sec_high, s_nxt.sec_low[SECTOR_LOW_BIT], 7'h00};
        // Read data, registered
        // Built from next-state values, so a read right after a write shows the new byte
        unique case (REG_ADDR)
            OFS_SECTOR_HIGH: s_nxt.rdata = s_nxt.sec_high;
            OFS_SECTOR_LOW: s_nxt.rdata = s_nxt.sec_low;
            OFS_USER_KEY: s_nxt.rdata = s_nxt.key;
            OFS_OP_CONTROL: s_nxt.rdata = {s_nxt.mode, s_nxt.fail, 2'b00, s_nxt.start};
            default: s_nxt.rdata = RESET_BYTE;
        endcase
    end

    // State register
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_r <= '{sec_high: RESET_BYTE, sec_low: RESET_BYTE, key: RESET_BYTE,
                     mode: RESET_BYTE[MODE_MSB:MODE_LSB], fail: 1'b0, start: 1'b0, st: ST_IDLE,
                     rdata: RESET_BYTE, addr: {RESET_BYTE, RESET_BYTE}, prog: 1'b0, erase: 1'b0, lock: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from flops
    assign REG_RDATA = s_r.rdata;
    assign FLASH_ADDR = s_r.addr;
    assign PROG_REQ = s_r.prog;
    assign ERASE_REQ = s_r.erase;
    assign LOCK_REQ = s_r.lock;

    // ==========================================================
    // Assertions
    sequence launch_s;
        s_r.st == ST_IDLE && s_r.start && key_ok && mode_ok;
    endsequence

    // Start write taken while the sequencer is idle
    sequence start_write_s;
        REG_WR && REG_ADDR == OFS_OP_CONTROL && REG_WDATA[START_BIT] && s_r.st == ST_IDLE;
    endsequence

    // Start seen with a bad key or code, and the control byte not rewritten
    sequence refuse_s;
        s_r.st == ST_IDLE && s_r.start && !(key_ok && mode_ok) && !(REG_WR && REG_ADDR == OFS_OP_CONTROL);
    endsequence

    key_gate_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        $rose(s_r.prog || s_r.erase || s_r.lock) |-> $past(key_ok))
        else $error("request without key");
    mode_prog_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        launch_s ##0 (s_r.mode == MODE_PROGRAM) |=> PROG_REQ && !ERASE_REQ && !LOCK_REQ)
        else $error("program code not mapped");
    mode_erase_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        launch_s ##0 (s_r.mode == MODE_ERASE) |=> ERASE_REQ && !PROG_REQ)
        else $error("erase code not mapped");
    bad_mode_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        (s_r.st == ST_IDLE && !mode_ok) |=> !(PROG_REQ || ERASE_REQ || LOCK_REQ))
        else $error("undefined mode acted");
    start_clear_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        (s_r.st == ST_BUSY && OP_DONE) |=> !s_r.start && s_r.st == ST_DONE)
        else $error("start not cleared on completion");
    erase_status_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        (s_r.st == ST_BUSY && OP_DONE && s_r.erase) |=> s_r.fail == $past(OP_FAIL))
        else $error("erase status wrong");
    addr_map_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        FLASH_ADDR[15:8] == s_r.sec_high)
        else $error("high address mismatch");
    low_mask_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        FLASH_ADDR[7:0] == {s_r.sec_low[7], 7'h00})
        else $error("low address bits leak");
    key_value_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        (REG_WR && REG_ADDR == OFS_USER_KEY && REG_WDATA != USER_KEY_VALUE) |=> !key_ok)
        else $error("wrong key accepted");

    // The right key must open the array on the next cycle
    key_open_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        (REG_WR && REG_ADDR == OFS_USER_KEY && REG_WDATA == USER_KEY_VALUE) |=> key_ok)
        else $error("right key refused");

    // A start write with a good key and code leads to a request two cycles on
    start_go_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        start_write_s ##1 (s_r.st == ST_IDLE && key_ok && mode_ok) |=> (PROG_REQ || ERASE_REQ || LOCK_REQ))
        else $error("start did not launch");

    // Hard lock code maps to the lock request only
    mode_lock_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        launch_s ##0 (s_r.mode == MODE_HARD_LOCK) |=> LOCK_REQ && !PROG_REQ && !ERASE_REQ)
        else $error("lock code not mapped");

    // At most one request at a time
    req_single_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        $onehot0({PROG_REQ, ERASE_REQ, LOCK_REQ}))
        else $error("several requests at once");

    // Refused start drops itself and raises nothing
    refuse_clear_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        refuse_s |=> !s_r.start && !(PROG_REQ || ERASE_REQ || LOCK_REQ))
        else $error("refused start lingered");

    // Software stop ends the running operation
    stop_halt_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        (s_r.st == ST_BUSY && !s_r.start) |=> s_r.st == ST_DONE && !(PROG_REQ || ERASE_REQ || LOCK_REQ))
        else $error("stop did not halt");

    // Erase status only moves on erase completion
    fail_hold_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        !(s_r.st == ST_BUSY && OP_DONE && s_r.erase) |=> $stable(s_r.fail))
        else $error("erase status moved");

    // High pointer write lands on address bits 15..8
    high_load_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        (REG_WR && REG_ADDR == OFS_SECTOR_HIGH) |=> FLASH_ADDR[15:8] == $past(REG_WDATA))
        else $error("high pointer not loaded");

    // Low pointer write moves address bit 7 only
    low_load_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        (REG_WR && REG_ADDR == OFS_SECTOR_LOW) |=> FLASH_ADDR[7:0] == ($past(REG_WDATA) & 8'h80))
        else $error("low pointer not loaded");
endmodule // flash_program_erase_control

// ===== hdl/flash_ctl_pkg.sv
// Constants for the flash program/erase control block
package flash_ctl_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFS_SECTOR_HIGH = 8'h08;
    localparam logic [7:0] OFS_SECTOR_LOW = 8'h09;
    localparam logic [7:0] OFS_USER_KEY = 8'h0A;
    localparam logic [7:0] OFS_OP_CONTROL = 8'h0B;
    // ==========================================================
    // Field positions and values
    localparam int MODE_MSB = 7;
    localparam int MODE_LSB = 4;
    localparam int FAIL_BIT = 3;
    localparam int START_BIT = 0;
    localparam int SECTOR_LOW_BIT = 7;
    localparam logic [3:0] MODE_PROGRAM = 4'h5;
    localparam logic [3:0] MODE_ERASE = 4'hA;
    localparam logic [3:0] MODE_HARD_LOCK = 4'h6;
    localparam logic [7:0] USER_KEY_VALUE = 8'hA5;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // ==========================================================
    // Operation states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_BUSY = 3'h2,
        ST_DONE = 3'h4
    } op_state_e;
endpackage : flash_ctl_pkg

// ===== dv/flash_program_erase_control_test.sv
// Self-checking bench for the flash program/erase control block
`timescale 1ns/100ps
module flash_program_erase_control_test;
    import flash_ctl_pkg::*;
    // ==========================================================
    // Bench signals
    logic ref_clk = 0, reset_n = 0, reg_wr = 0, op_done = 0, op_fail = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [15:0] flash_addr;
    logic prog_req, erase_req, lock_req, fail_st = 0;
    logic [2:0] seen;
    int err_count = 0, tests_run = 0;
    flash_program_erase_control dut_u (.REF_CLK(ref_clk), .RESET_N(reset_n), .REG_ADDR(reg_addr),
        .REG_WR(reg_wr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .FLASH_ADDR(flash_addr),
        .PROG_REQ(prog_req), .ERASE_REQ(erase_req), .LOCK_REQ(lock_req), .OP_DONE(op_done), .OP_FAIL(op_fail));
    // 25 MHz clock
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    // ==========================================================
    // Tasks
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One-cycle write strobe, released a cycle later so strobes never merge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk) #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge ref_clk) #1;
        reg_wr = 1'b0;
    endtask
    // Read data lags the address by one cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk) #1;
        reg_addr = a;
        @(posedge ref_clk) #1;
        chk($sformatf("register %h", a), {8'h00, exp}, {8'h00, reg_rdata});
    endtask
    // Start, collect requests, complete from the array side, read control back
    task automatic op(input logic [7:0] ctl, input logic [2:0] exp_req, input logic fl);
        seen = 3'b000;
        wr(OFS_OP_CONTROL, ctl);
        repeat (4) begin
            @(posedge ref_clk) #1;
            seen = seen | {prog_req, erase_req, lock_req};
        end
        chk("requests raised", {13'h0000, exp_req}, {13'h0000, seen});
        if (exp_req != 3'b000) begin
            op_fail = fl;
            op_done = 1'b1;
            @(posedge ref_clk) #1;
            op_done = 1'b0;
            if (exp_req == 3'b010) fail_st = fl;
        end
        repeat (3) @(posedge ref_clk);
        rd(OFS_OP_CONTROL, {ctl[7:4], fail_st, 3'b000});
        chk("requests idle", 16'h0000, {13'h0000, prog_req, erase_req, lock_req});
    endtask
    // ==========================================================
    // Test sequence
    initial begin
        repeat (12) @(posedge ref_clk);
        #1 reset_n = 1'b1;
        rd(OFS_SECTOR_HIGH, 8'h00);
        rd(OFS_SECTOR_LOW, 8'h00);
        rd(OFS_USER_KEY, 8'h00);
        rd(OFS_OP_CONTROL, 8'h00);
        rd(8'h0C, 8'h00);
        $display("test reset values done");
        // Low pointer bits 6..0 must not move the sector
        wr(OFS_SECTOR_HIGH, 8'h5A);
        wr(OFS_SECTOR_LOW, 8'h7F);
        rd(OFS_SECTOR_LOW, 8'h7F);
        chk("flash address", 16'h5A00, flash_addr);
        wr(OFS_SECTOR_LOW, 8'h80);
        rd(OFS_SECTOR_HIGH, 8'h5A);
        chk("flash address", 16'h5A80, flash_addr);
        $display("test sector pointer done");
        op(8'hA1, 3'b000, 1'b0);
        wr(OFS_USER_KEY, 8'hA4);
        op(8'h51, 3'b000, 1'b0);
        $display("test locked done");
        wr(OFS_USER_KEY, USER_KEY_VALUE);
        rd(OFS_USER_KEY, 8'hA5);
        op(8'h51, 3'b100, 1'b1);
        op(8'hA1, 3'b010, 1'b1);
        op(8'h61, 3'b001, 1'b0);
        op(8'hA1, 3'b010, 1'b0);
        op(8'h39, 3'b000, 1'b0);
        op(8'hF1, 3'b000, 1'b0);
        $display("test modes done");
        // Stop in mid-operation by clearing the start bit
        wr(OFS_OP_CONTROL, 8'h51);
        repeat (3) @(posedge ref_clk);
        #1 chk("program request", 16'h0001, {15'h0000, prog_req});
        wr(OFS_OP_CONTROL, 8'h50);
        repeat (2) @(posedge ref_clk);
        #1 chk("program request", 16'h0000, {15'h0000, prog_req});
        rd(OFS_OP_CONTROL, 8'h50);
        $display("test stop done");
        conclude();
    end
    // Run needs under 150 cycles; allow 4000, over twenty-five times that
    initial begin
        #(40 * 4000);
        err_count++;
        conclude();
    end
endmodule // flash_program_erase_control_test
